// *** logic/utc_ctrl.v ***
// Transceiver control logic: modes, steering, pull-ups and timers
// Overview of operation
// - Legacy host raises interrupt, no auto enable
// - Transceiver may be enabled in boot mode
// - Two select bits choose four interface modes
// - Boot mode takes default mode from straps
// - Transmit enable low drives, high receives
// - SE0 forcing, SE0 report, suspend D+ only
// - Speed pull-up on D+ or D-
// - Suspend lowers power, Schmitt receivers, supplies on
// - Independent pull-downs on D+ and D-
// - Timer holds D+ pull-up 5 to 10 ms
// - VBUS pulsing with current limit and timer
// - Auto-connect pull-up when SE0 seen
// - Supply defaults to application, reselectable
// - Report valid VBUS and session request
`timescale 1ns/1ns
`include "utc_map.vh"
module utc_ctrl #(
	parameter SRP_US     = `UTC_SRP_US,
	parameter CLK_MHZ    = `UTC_CLK_MHZ,
	parameter VP_STEP_US = `UTC_VP_STEP_US,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
) (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       nrst,
	// Serial control bits
	input  wire       ctl_transceiver_on,
	input  wire       ctl_supply_on,
	input  wire [1:0] ctl_supply_sel,
	input  wire       ctl_mode_write,
	input  wire [1:0] ctl_mode_data,
	input  wire       ctl_pullup_full,
	input  wire       ctl_pullup_low,
	input  wire       ctl_suspend,
	input  wire       ctl_pulldown_plus,
	input  wire       ctl_pulldown_minus,
	input  wire       ctl_srp_start,
	input  wire       ctl_auto_connect,
	input  wire       ctl_vbus_pulse_start,
	input  wire [3:0] ctl_vbus_pulse_len,
	input  wire       ctl_vbus_low_limit,
	input  wire       ctl_legacy_ack,
	// Pins and analog status
	input  wire       transceiver_enable_pin,
	input  wire       mode_strap_0,
	input  wire       mode_strap_0_open,
	input  wire       mode_strap_1,
	input  wire       legacy_host_seen,
	input  wire       vbus_valid_cmp,
	input  wire       session_req_cmp,
	// Processor-side pins
	input  wire       transmit_enable_n,
	input  wire       data_or_plus_pin_in,
	output reg        data_or_plus_pin_out,
	output reg        data_or_plus_pin_oe,
	input  wire       se0_or_minus_pin_in,
	output reg        se0_or_minus_pin_out,
	output reg        se0_or_minus_pin_oe,
	output reg        rx_plus_out,
	output reg        rx_minus_out,
	output reg        rx_differential_out,
	// Cable side
	input  wire       cable_plus_pin_in,
	input  wire       cable_minus_pin_in,
	output reg        cable_plus_pin_out,
	output reg        cable_minus_pin_out,
	output reg        cable_drive_en,
	// Analog controls
	output reg        pullup_plus_en,
	output reg        pullup_minus_en,
	output reg        pulldown_plus_en,
	output reg        pulldown_minus_en,
	output reg        low_power_en,
	output reg        schmitt_sel,
	output reg        transceiver_active,
	output reg        supply_regulator_on,
	output reg  [1:0] supply_source,
	output reg        vbus_detect_on,
	output reg        vbus_pulse_on,
	output reg        vbus_low_limit,
	// Status and event
	output reg        legacy_host_irq,
	output reg        vbus_valid,
	output reg        session_req,
	output reg  [1:0] interface_mode,
	output reg        boot_mode
);
	// Cycle counts derived from times
	localparam SRP_CYC  = SRP_US * CLK_MHZ;
	localparam STEP_CYC = VP_STEP_US * CLK_MHZ;

	wire [9:0] pin_sync;
	wire       s_ten_pin;
	wire       s_strap0;
	wire       s_strap0_open;
	wire       s_strap1;
	wire       s_legacy;
	wire       s_cab_p;
	wire       s_cab_m;
	wire       s_txen_n;
	wire       s_dp;
	wire       s_se;
	wire [1:0] rx_sync;
	wire       s_vbus;
	wire       s_srq;
	reg  [3:0] strap_wait;
	reg  [1:0] next_mode;
	reg        legacy_prev;
	reg [23:0] srp_cnt;
	reg        srp_active;
	reg [19:0] step_cnt;
	reg  [3:0] vp_cnt;
	reg        auto_latched;
	reg        fifo_in_valid;
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [2:0] fifo_out_data;
	reg  [2:0] rx_word;
	wire       se_mode;
	wire       bidirectional_select_mode;
	wire       line_se0;

	// Pin levels from outside cross two flops
	utc_sync #(.WIDTH(10)) u_pins (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_in ({data_or_plus_pin_in, se0_or_minus_pin_in, transceiver_enable_pin,
			mode_strap_0, mode_strap_0_open, mode_strap_1, legacy_host_seen,
			cable_plus_pin_in, cable_minus_pin_in, transmit_enable_n}),
		.sync_out (pin_sync)
	);
	assign s_ten_pin     = pin_sync[7];
	assign s_strap0      = pin_sync[6];
	assign s_strap0_open = pin_sync[5];
	assign s_strap1      = pin_sync[4];
	assign s_legacy      = pin_sync[3];
	assign s_cab_p       = pin_sync[2];
	assign s_cab_m       = pin_sync[1];
	assign s_txen_n      = pin_sync[0];
	assign s_dp          = pin_sync[9];
	assign s_se          = pin_sync[8];

	// Comparator outputs cross two flops
	utc_sync #(.WIDTH(2)) u_cmp (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_in ({vbus_valid_cmp, session_req_cmp}),
		.sync_out (rx_sync)
	);
	assign s_vbus = rx_sync[1];
	assign s_srq  = rx_sync[0];

	assign se_mode    = interface_mode[`UTC_MODE_SE_BIT];
	assign bidirectional_select_mode = interface_mode[`UTC_MODE_BIDIRECTIONAL_SELECT_BIT];
	assign line_se0   = ({s_cab_p, s_cab_m} == `UTC_LINE_SE0);

	// Strap decode to mode bits
	function [1:0] strap_mode;
		input s0;
		input s0_open;
		input s1;
		begin
			if (s1)
				strap_mode = `UTC_MODE_DIFF_6W;
			else if (s0_open)
				strap_mode = `UTC_MODE_SE_3W;
			else if (s0)
				strap_mode = `UTC_MODE_DIFF_4W;
			else
				strap_mode = `UTC_MODE_SE_6W;
		end
	endfunction

	// Next mode: straps at boot, serial write otherwise
	always @* begin
		next_mode = interface_mode;
		if (boot_mode && strap_wait == `UTC_STRAP_WAIT)
			next_mode = strap_mode(s_strap0, s_strap0_open, s_strap1);
		else if (ctl_mode_write && !boot_mode)
			next_mode = ctl_mode_data;
	end

	// Boot detect and mode register
	always @(posedge ref_clk) begin
		if (!nrst) begin
			strap_wait     <= 4'h0;
			boot_mode      <= 1'b0;
			interface_mode <= `UTC_MODE_RESET;
		end else begin
			if (strap_wait != `UTC_STRAP_WAIT + 4'h1)
				strap_wait <= strap_wait + 4'h1;
			if (strap_wait == `UTC_STRAP_WAIT - 4'h1)
				boot_mode <= s_ten_pin;
			else if (strap_wait > `UTC_STRAP_WAIT && !s_ten_pin)
				boot_mode <= 1'b0;
			interface_mode <= next_mode;
		end
	end

	// Legacy host event, sticky until acknowledged, set wins
	always @(posedge ref_clk) begin
		if (!nrst) begin
			legacy_prev     <= 1'b0;
			legacy_host_irq <= 1'b0;
		end else begin
			legacy_prev <= s_legacy;
			if (s_legacy && !legacy_prev)
				legacy_host_irq <= 1'b1;
			else if (ctl_legacy_ack)
				legacy_host_irq <= 1'b0;
		end
	end

	// Enables from software or boot pin; VBUS detect always on
	always @(posedge ref_clk) begin
		if (!nrst) begin
			transceiver_active  <= 1'b0;
			supply_regulator_on <= 1'b0;
			supply_source       <= `UTC_SUP_APP;
			vbus_detect_on      <= 1'b0;
			low_power_en        <= 1'b0;
			schmitt_sel         <= 1'b0;
		end else begin
			transceiver_active  <= ctl_transceiver_on | boot_mode;
			supply_regulator_on <= ctl_supply_on | boot_mode | ctl_suspend;
			supply_source       <= (ctl_supply_sel == `UTC_SUP_VBUS) ? `UTC_SUP_VBUS :
				(ctl_supply_sel == `UTC_SUP_BOOST) ? `UTC_SUP_BOOST : `UTC_SUP_APP;
			vbus_detect_on      <= 1'b1;
			low_power_en        <= ctl_suspend;
			schmitt_sel         <= ctl_suspend;
		end
	end

	// Session request timer holds D+ pull-up
	always @(posedge ref_clk) begin
		if (!nrst) begin
			srp_cnt    <= 24'h00_0000;
			srp_active <= 1'b0;
		end else if (ctl_srp_start && !srp_active) begin
			srp_cnt    <= SRP_CYC[23:0] - 24'h00_0001;
			srp_active <= 1'b1;
		end else if (srp_active) begin
			if (srp_cnt == 24'h00_0000)
				srp_active <= 1'b0;
			else
				srp_cnt <= srp_cnt - 24'h00_0001;
		end
	end

	// VBUS pulse timer in steps
	always @(posedge ref_clk) begin
		if (!nrst) begin
			step_cnt       <= 20'h0_0000;
			vp_cnt         <= 4'h0;
			vbus_pulse_on  <= 1'b0;
			vbus_low_limit <= 1'b0;
		end else begin
			vbus_low_limit <= ctl_vbus_low_limit;
			if (ctl_vbus_pulse_start && !vbus_pulse_on && ctl_vbus_pulse_len != 4'h0) begin
				vbus_pulse_on <= 1'b1;
				vp_cnt        <= ctl_vbus_pulse_len;
				step_cnt      <= STEP_CYC[19:0] - 20'h0_0001;
			end else if (vbus_pulse_on) begin
				if (step_cnt != 20'h0_0000) begin
					step_cnt <= step_cnt - 20'h0_0001;
				end else if (vp_cnt == 4'h1) begin
					vbus_pulse_on <= 1'b0;
				end else begin
					vp_cnt   <= vp_cnt - 4'h1;
					step_cnt <= STEP_CYC[19:0] - 20'h0_0001;
				end
			end
		end
	end

	// Auto-connect latch on SE0 while enabled
	always @(posedge ref_clk) begin
		if (!nrst)
			auto_latched <= 1'b0;
		else if (!ctl_auto_connect)
			auto_latched <= 1'b0;
		else if (line_se0 && transceiver_active)
			auto_latched <= 1'b1;
	end

	// Pull resistors and comparator status
	always @(posedge ref_clk) begin
		if (!nrst) begin
			pullup_plus_en    <= 1'b0;
			pullup_minus_en   <= 1'b0;
			pulldown_plus_en  <= 1'b0;
			pulldown_minus_en <= 1'b0;
			vbus_valid        <= 1'b0;
			session_req       <= 1'b0;
		end else begin
			pullup_plus_en    <= ctl_pullup_full | srp_active | auto_latched;
			pullup_minus_en   <= ctl_pullup_low & ~ctl_pullup_full;
			pulldown_plus_en  <= ctl_pulldown_plus;
			pulldown_minus_en <= ctl_pulldown_minus;
			vbus_valid        <= s_vbus;
			session_req       <= s_srq;
		end
	end

	// Received line samples queue toward processor pins
	always @* begin
		fifo_in_valid = transceiver_active & s_txen_n;
	end

	utc_fifo #(.WIDTH(3), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxq (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   ({s_cab_p, s_cab_m, s_cab_p & ~s_cab_m}),
		.out_valid (fifo_out_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out_data)
	);

	// Hold latest received word
	always @(posedge ref_clk) begin
		if (!nrst)
			rx_word <= 3'h0;
		else if (fifo_out_valid)
			rx_word <= fifo_out_data;
	end

	// Steering between processor pins and cable
	always @(posedge ref_clk) begin
		if (!nrst) begin
			cable_plus_pin_out   <= 1'b0;
			cable_minus_pin_out  <= 1'b0;
			cable_drive_en       <= 1'b0;
			data_or_plus_pin_out <= 1'b0;
			data_or_plus_pin_oe  <= 1'b0;
			se0_or_minus_pin_out <= 1'b0;
			se0_or_minus_pin_oe  <= 1'b0;
			rx_plus_out          <= 1'b0;
			rx_minus_out         <= 1'b0;
			rx_differential_out  <= 1'b0;
		end else begin
			cable_drive_en      <= transceiver_active & ~s_txen_n;
			data_or_plus_pin_oe <= transceiver_active & s_txen_n & bidirectional_select_mode;
			se0_or_minus_pin_oe <= transceiver_active & s_txen_n & bidirectional_select_mode;
			rx_differential_out <= rx_word[0];
			rx_plus_out         <= bidirectional_select_mode ? 1'b0 : rx_word[2];
			rx_minus_out        <= bidirectional_select_mode ? 1'b0 : rx_word[1];
			if (se_mode) begin
				// Forced SE0 overrides data
				cable_plus_pin_out  <= s_se ? 1'b0 : s_dp;
				cable_minus_pin_out <= s_se ? 1'b0 : ~s_dp;
				data_or_plus_pin_out <= (ctl_suspend | !fifo_in_ready) ? rx_word[2] : rx_word[0];
				se0_or_minus_pin_out <= (rx_word[2:1] == `UTC_LINE_SE0);
			end else begin
				cable_plus_pin_out   <= s_dp;
				cable_minus_pin_out  <= s_se;
				data_or_plus_pin_out <= rx_word[2];
				se0_or_minus_pin_out <= rx_word[1];
			end
		end
	end
endmodule // utc_ctrl

// *** logic/utc_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module utc_fifo #(
	parameter WIDTH = 3,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             nrst,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	reg             out_full;
	wire            push;
	wire            pop;
	wire            load;

	// Output register holds head word
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = out_full;
	assign push      = in_valid & in_ready;
	assign load      = (count != {(AW+1){1'b0}}) & (~out_full | out_ready);
	assign pop       = out_full & out_ready;

	// Storage write
	always @(posedge ref_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers, count and output stage
	always @(posedge ref_clk) begin
		if (!nrst) begin
			wr_ptr   <= {AW{1'b0}};
			rd_ptr   <= {AW{1'b0}};
			count    <= {(AW+1){1'b0}};
			out_full <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (load) begin
				rd_ptr   <= rd_ptr + 1'b1;
				out_data <= mem[rd_ptr];
				out_full <= 1'b1;
			end else if (pop) begin
				out_full <= 1'b0;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
		end
	end
endmodule // utc_fifo

// *** logic/utc_map.vh ***
// Constants for the transceiver control block
`ifndef UTC_MAP_VH
`define UTC_MAP_VH
// Interface mode encodings {single_ended_select, bidirectional_select}
`define UTC_MODE_DIFF_6W   2'h0
`define UTC_MODE_DIFF_4W   2'h1
`define UTC_MODE_SE_6W     2'h2
`define UTC_MODE_SE_3W     2'h3
// Mode field positions
`define UTC_MODE_SE_BIT    1
`define UTC_MODE_BIDIRECTIONAL_SELECT_BIT 0
// Reset value of mode bits outside boot
`define UTC_MODE_RESET     2'h0
// Supply select encodings
`define UTC_SUP_APP        2'h0
`define UTC_SUP_BOOST      2'h1
`define UTC_SUP_VBUS       2'h2
// Session request pulse, in microseconds, within 5 to 10 ms
`define UTC_SRP_US         7500
`define UTC_CLK_MHZ        100
// VBUS pulse timer step, in microseconds
`define UTC_VP_STEP_US     1000
// Boot strap sampling delay after reset release
`define UTC_STRAP_WAIT     4'h3
// Line states on {plus, minus}
`define UTC_LINE_SE0       2'h0
`endif

// *** logic/utc_sync.v ***
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module utc_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             nrst,
	// Levels
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta;

	// First stage feeds only the second
	always @(posedge ref_clk) begin
		if (!nrst) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // utc_sync

// *** tb/usb_transceiver_control_bench.sv ***
// Self-checking bench for the transceiver control block
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
	$display("ERROR %0t got %h exp %h", $time, a, e); end end
module usb_transceiver_control_bench;
	logic ref_clk = 0, nrst = 0, ctl_transceiver_on = 0, ctl_supply_on = 0, ctl_mode_write = 0;
	logic ctl_pullup_full = 0, ctl_pullup_low = 0, ctl_suspend = 0, ctl_pulldown_plus = 0;
	logic ctl_pulldown_minus = 0, ctl_srp_start = 0, ctl_auto_connect = 0, ctl_legacy_ack = 0;
	logic ctl_vbus_pulse_start = 0, ctl_vbus_low_limit = 0, transceiver_enable_pin = 0;
	logic mode_strap_0 = 0, mode_strap_0_open = 0, mode_strap_1 = 0, legacy_host_seen = 0;
	logic vbus_valid_cmp = 0, session_req_cmp = 0, transmit_enable_n = 1, tb_dp = 0, tb_se = 0;
	logic [1:0] ctl_supply_sel = 0, ctl_mode_data = 0, supply_source, interface_mode;
	logic [3:0] ctl_vbus_pulse_len = 0;
	logic data_or_plus_pin_out, data_or_plus_pin_oe, se0_or_minus_pin_out, se0_or_minus_pin_oe;
	logic rx_plus_out, rx_minus_out, rx_differential_out, cable_plus_pin_out, cable_minus_pin_out;
	logic cable_drive_en, cable_plus_pin_in, cable_minus_pin_in, pullup_plus_en, pullup_minus_en;
	logic pulldown_plus_en, pulldown_minus_en, low_power_en, schmitt_sel, transceiver_active;
	logic supply_regulator_on, vbus_detect_on, vbus_pulse_on, vbus_low_limit, legacy_host_irq;
	logic vbus_valid, session_req, boot_mode;
	logic [2:0] straps [4] = '{3'h5, 3'h4, 3'h0, 3'h2};
	int errors = 0, cmp_count = 0, n;
	// Processor pins: the device wins while it drives
	wire data_or_plus_pin_in = data_or_plus_pin_oe ? data_or_plus_pin_out : tb_dp;
	wire se0_or_minus_pin_in = se0_or_minus_pin_oe ? se0_or_minus_pin_out : tb_se;
	utc_ctrl #(.SRP_US(1), .VP_STEP_US(1)) dut (.*);
	utc_cable_model cab (.*);
	// Clock at 100 MHz
	always #5 ref_clk = ~ref_clk;
	// Whole cycles, then settle past the edge
	task tick(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	// Reset with boot pin and straps {strap 0, open, strap 1}
	task rst(input logic pin, input logic [2:0] s);
		nrst = 0;
		transceiver_enable_pin = pin;
		{mode_strap_0, mode_strap_0_open, mode_strap_1} = s;
		tick(4);
		nrst = 1;
		tick(6);
	endtask
	// One mode write
	task set_mode(input logic [1:0] m);
		ctl_mode_data = m;
		ctl_mode_write = 1;
		tick(1);
		ctl_mode_write = 0;
	endtask
	// Start a pulse, repeat the start at cycle 50, count its high cycles
	task measure(input bit vb, output int c);
		int t;
		c = 0;
		for (t = 0; t < 600 && (c == 0 || (vb ? vbus_pulse_on : pullup_plus_en)); t++) begin
			ctl_srp_start = !vb && t inside {0, 50};
			ctl_vbus_pulse_start = vb && t inside {0, 50};
			tick(1);
			c += vb ? vbus_pulse_on : pullup_plus_en;
		end
		ctl_srp_start = 0;
		ctl_vbus_pulse_start = 0;
		// Wait limit used up counts as a mismatch and ends the run
		if (t == 600) begin
			errors++;
			complete_run();
		end
	endtask
	// Counts and verdict
	task complete_run;
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		for (int i = 0; i < 4; i++) begin
			rst(1, straps[i]);
			`CHK(boot_mode, 1'h1)
			`CHK(interface_mode, i[1:0])
			`CHK(transceiver_active, 1'h1)
			set_mode(~i[1:0]);
			tick(1);
			`CHK(interface_mode, i[1:0])
		end
		$display("test boot done");
		rst(0, 3'h0);
		`CHK({boot_mode, interface_mode, supply_source}, 5'h00)
		legacy_host_seen = 1;
		tick(6);
		`CHK({legacy_host_irq, transceiver_active, supply_regulator_on}, 3'h4)
		ctl_legacy_ack = 1;
		tick(1);
		ctl_legacy_ack = 0;
		tick(1);
		`CHK(legacy_host_irq, 1'h0)
		ctl_transceiver_on = 1;
		ctl_supply_on = 1;
		tick(2);
		`CHK({transceiver_active, supply_regulator_on}, 2'h3)
		for (int s = 0; s < 4; s++) begin
			ctl_supply_sel = s[1:0];
			tick(2);
			`CHK(supply_source, s == 3 ? 2'h0 : s[1:0])
		end
		$display("test legacy done");
		for (int m = 0; m < 4; m++) begin
			set_mode(m[1:0]);
			`CHK(interface_mode, m[1:0])
			transmit_enable_n = 0;
			tb_dp = 1;
			tick(8);
			`CHK({cable_drive_en, cable_plus_pin_out, cable_minus_pin_out}, 3'h6)
			tb_se = 1;
			tick(6);
			`CHK({cable_plus_pin_out, cable_minus_pin_out}, m[1] ? 2'h0 : 2'h3)
			transmit_enable_n = 1;
			tb_dp = 0;
			tb_se = 0;
			cab.put_line(1, 2'h2);
			tick(10);
			if (m[0]) `CHK({data_or_plus_pin_out, data_or_plus_pin_oe, se0_or_minus_pin_oe,
				cable_drive_en}, 4'he)
			else `CHK({rx_plus_out, rx_minus_out, rx_differential_out, cable_drive_en}, 4'ha)
			if (m == 3) begin
				cab.put_line(1, 2'h0);
				tick(10);
				`CHK(se0_or_minus_pin_out, 1'h1)
				ctl_suspend = 1;
				cab.put_line(1, 2'h3);
				tick(10);
				`CHK(data_or_plus_pin_out, 1'h1)
				`CHK({low_power_en, schmitt_sel, vbus_detect_on, supply_regulator_on}, 4'hf)
				ctl_suspend = 0;
			end
			cab.put_line(0, 2'h0);
		end
		$display("test modes done");
		for (int k = 0; k < 4; k++) begin
			{ctl_pullup_full, ctl_pullup_low} = k[1:0];
			{ctl_pulldown_plus, ctl_pulldown_minus} = k[1:0];
			tick(2);
			`CHK({pullup_plus_en, pullup_minus_en}, k == 3 ? 2'h2 : k[1:0])
			`CHK({pulldown_plus_en, pulldown_minus_en}, k[1:0])
		end
		{ctl_pullup_full, ctl_pullup_low} = 2'h0;
		tick(2);
		measure(0, n);
		`CHK(n, 100)
		ctl_vbus_low_limit = 1;
		ctl_vbus_pulse_len = 4'h2;
		measure(1, n);
		`CHK(n, 200)
		`CHK(vbus_low_limit, 1'h1)
		ctl_vbus_pulse_len = 4'h0;
		ctl_vbus_pulse_start = 1;
		tick(4);
		`CHK(vbus_pulse_on, 1'h0)
		ctl_vbus_pulse_start = 0;
		ctl_auto_connect = 1;
		tick(8);
		`CHK(pullup_plus_en, 1'h1)
		ctl_auto_connect = 0;
		tick(2);
		`CHK(pullup_plus_en, 1'h0)
		vbus_valid_cmp = 1;
		session_req_cmp = 1;
		tick(5);
		`CHK({vbus_valid, session_req}, 2'h3)
		$display("test timers done");
		complete_run();
	end
endmodule // usb_transceiver_control_bench

// *** tb/utc_cable_model.sv ***
// Far-end cable model: far line states and bus resolution
`timescale 1ns/1ns
module utc_cable_model (
	// Device drive and pull resistors
	input wire logic  ref_clk, cable_drive_en, cable_plus_pin_out, cable_minus_pin_out,
	input wire logic  pullup_plus_en, pullup_minus_en,
	// Resolved cable levels
	output wire logic cable_plus_pin_in, cable_minus_pin_in
);
	logic       far_on  = 1'h0;
	logic [1:0] far_val = 2'h0;
	// Device drive first, then the far end, then pull-up or pull-down
	assign cable_plus_pin_in = cable_drive_en ? cable_plus_pin_out :
		far_on ? far_val[1] : pullup_plus_en;
	assign cable_minus_pin_in = cable_drive_en ? cable_minus_pin_out :
		far_on ? far_val[0] : pullup_minus_en;
	// Far end takes or releases the line just after an edge
	task put_line(input logic on, input logic [1:0] v);
		@(posedge ref_clk);
		#1;
		far_on = on;
		far_val = v;
	endtask
endmodule // utc_cable_model

// *** tb/utc_ctrl_chk.sv ***
// Assertion checker for the transceiver control block
`timescale 1ns/1ns
module utc_ctrl_chk #(
	parameter SRP_US  = 7500,
	parameter CLK_MHZ = 100
) (
	// Clock, reset and control bits
	input wire logic       ref_clk, nrst, ctl_transceiver_on, ctl_mode_write,
	input wire logic [1:0] ctl_mode_data,
	input wire logic       ctl_pullup_full, ctl_suspend, ctl_auto_connect, ctl_legacy_ack,
	// Pins
	input wire logic       transceiver_enable_pin, legacy_host_seen, transmit_enable_n,
	input wire logic       se0_or_minus_pin_in,
	// Outputs
	input wire logic       cable_plus_pin_out, cable_minus_pin_out, cable_drive_en,
	input wire logic       pullup_plus_en, pullup_minus_en, low_power_en, schmitt_sel,
	input wire logic       transceiver_active, vbus_detect_on, legacy_host_irq, boot_mode,
	input wire logic [1:0] interface_mode
);
	localparam int SRP_CYC = SRP_US * CLK_MHZ;
	int srp_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Cycles of D+ pull-up owed to the session timer alone
	always @(posedge ref_clk)
		srp_cnt <= (!nrst || !pullup_plus_en || ctl_pullup_full || ctl_auto_connect) ?
			0 : srp_cnt + 1;
	AST_IRQ_RAISE:
		assert property ($rose(legacy_host_seen) |-> ##[1:5] legacy_host_irq)
		else $error("no event after legacy host");
	AST_IRQ_HOLD:
		assert property (legacy_host_irq && !ctl_legacy_ack |=> legacy_host_irq)
		else $error("event dropped without ack");
	AST_NO_AUTO:
		assert property (!boot_mode && !transceiver_enable_pin && !ctl_transceiver_on
			|=> !transceiver_active) else $error("transceiver on by itself");
	AST_MODE_WR:
		assert property (!boot_mode && ctl_mode_write |=> interface_mode == $past(ctl_mode_data))
		else $error("mode write not applied");
	AST_TX_DRIVE:
		assert property ((transceiver_active && !transmit_enable_n) [*5] |-> cable_drive_en)
		else $error("no drive while transmitting");
	AST_SE0_FORCE:
		assert property ((!transmit_enable_n && se0_or_minus_pin_in && interface_mode[1]) [*5]
			|-> !cable_plus_pin_out && !cable_minus_pin_out) else $error("SE0 not forced");
	AST_PULL_FULL:
		assert property (ctl_pullup_full |=> pullup_plus_en && !pullup_minus_en)
		else $error("full speed pull-up wrong");
	AST_SUSPEND:
		assert property (ctl_suspend |=> low_power_en && schmitt_sel && vbus_detect_on)
		else $error("suspend state wrong");
	AST_SRP_LEN:
		assert property (srp_cnt <= SRP_CYC) else $error("session pull-up too long");
endmodule // utc_ctrl_chk

bind utc_ctrl utc_ctrl_chk #(.SRP_US(SRP_US), .CLK_MHZ(CLK_MHZ)) u_chk (.*);
